/* dv/card_model.sv */
`timescale 1ns/1ns
// card side: raises or drops its request some cycles after being told to
module card_model (
  // bench controls
  input  wire logic       ref_clk,
  input  wire logic       want_req,
  input  wire logic       pull_card,
  input  wire logic [3:0] lag,
  // card pins
  output logic            card_dreq,
  output logic            card_removed
);
  logic [3:0] cnt_q;

  initial begin
    card_dreq = 1'b0;
    card_removed = 1'b0;
    cnt_q = 4'h0;
  end

  always @(posedge ref_clk) begin
    card_removed <= pull_card;
    if (want_req == card_dreq) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= lag) card_dreq <= want_req;
    end
  end
endmodule // card_model

/* dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import distributed_dma_gate_pkg::*;
  logic              ref_clk = 1'b0, rst_b = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        lag = 4'h0;
  logic [3:0]        wstrb = 4'hF;
  logic [1:0]        bresp, rresp;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              want_req = 1'b0, pull_card = 1'b0, tc_hit = 1'b0;
  logic              card_dreq, card_removed, gate, service, clear_seen;
  logic [33:0]       exp_r[$];
  logic [2:0]        exp_b[$];
  int                n_mismatch = 0, n_compared = 0, cyc = 0;

  always #10 ref_clk = ~ref_clk;

  distributed_dma_clear_and_request_mask dut (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .card_dreq(card_dreq), .card_removed(card_removed), .terminal_count_hit(tc_hit),
    .request_gate_bit(gate), .dma_service_request(service), .controller_clear(clear_seen));

  card_model card (.ref_clk(ref_clk), .want_req(want_req), .pull_card(pull_card),
    .lag(lag), .card_dreq(card_dreq), .card_removed(card_removed));

  //////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (e !== g) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk);
    // clear pulse is expected alongside the response of a clear write
    exp_b.push_back({a == CLEAR_ADDR, er});
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge ref_clk);
      if (awready && awvalid) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && wvalid) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task rd(input logic [9:0] a, input logic [33:0] e);
    @(posedge ref_clk);
    exp_r.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task pulse_tc;
    tc_hit <= 1'b1;
    @(posedge ref_clk);
    tc_hit <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // response watcher and hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rvalid && rready) chk("read", exp_r.pop_front(), {rresp, rdata});
    if (bvalid && bready) begin
      chk("bresp_clear", {31'h0, exp_b.pop_front()}, {31'h0, clear_seen, bresp});
    end
    if (cyc == 4000) begin
      n_mismatch++;
      stop_test;
    end
  end

  initial begin
    void'($urandom(32'h2006));
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(GATE_ADDR, {RESP_OKAY, 32'h1});
    chk("gate", 34'h1, {33'h0, gate});
    rd(STATUS_ADDR, {RESP_OKAY, 32'h0});
    want_req <= 1'b1;
    lag <= 4'h3;
    repeat (12) @(posedge ref_clk);
    chk("service", 34'h0, {33'h0, service});
    rd(STATUS_ADDR, {RESP_OKAY, 32'hF0});
    wr(GATE_ADDR, $urandom & 32'hFFFF_FFFE, RESP_OKAY);
    rd(GATE_ADDR, {RESP_OKAY, 32'h0});
    repeat (2) @(posedge ref_clk);
    chk("service", 34'h1, {33'h0, service});
    pulse_tc();
    rd(STATUS_ADDR, {RESP_OKAY, 32'hFF});
    rd(STATUS_ADDR, {RESP_OKAY, 32'hF0});
    want_req <= 1'b0;
    repeat (10) @(posedge ref_clk);
    pulse_tc();
    wr(CLEAR_ADDR, $urandom, RESP_OKAY);
    rd(GATE_ADDR, {RESP_OKAY, 32'h1});
    rd(STATUS_ADDR, {RESP_OKAY, 32'h0});
    wr(GATE_ADDR, 32'h0, RESP_OKAY);
    wstrb <= 4'hE;
    wr(GATE_ADDR, 32'h1, RESP_OKAY);
    wstrb <= 4'hF;
    rd(GATE_ADDR, {RESP_OKAY, 32'h0});
    pull_card <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(GATE_ADDR, {RESP_OKAY, 32'h1});
    chk("gate", 34'h1, {33'h0, gate});
    wr(GATE_ADDR, 32'h0, RESP_OKAY);
    rd(GATE_ADDR, {RESP_OKAY, 32'h1});
    pull_card <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wr(GATE_ADDR, 32'h0, RESP_OKAY);
    rd(GATE_ADDR, {RESP_OKAY, 32'h0});
    rd(CLEAR_ADDR, {RESP_OKAY, 32'h0});
    wr(10'h100, $urandom, RESP_SLVERR);
    rd(10'h100, {RESP_SLVERR, 32'h0});
    repeat (4) @(posedge ref_clk);
    stop_test();
  end
endmodule // testbench

/* rtl/distributed_dma_clear_and_request_mask.sv */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
// Summary of operation
// - any clear write resets whole controller
// - gate register holds only bit zero
// - card removal sets the gate bit
// - gate set: card requests ignored
// - gate clear: card requests serviced
// - gate bit comes up set
// - gate bits seven to one read zero
// - request status follows card line always
// - terminal count sets, read or reset clears
module distributed_dma_clear_and_request_mask
  import distributed_dma_gate_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // card pins
  input  wire logic              card_dreq,
  input  wire logic              card_removed,
  // controller side
  input  wire logic              terminal_count_hit,
  output logic                   request_gate_bit,
  output logic                   dma_service_request,
  output logic                   controller_clear
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic       rst_meta_q;
  logic       rst_n_q;
  logic [1:0] dreq_sync_q;
  logic [1:0] removed_sync_q;
  logic       dreq_s;
  logic       removed_s;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dreq_sync_q    <= 2'h0;
      removed_sync_q <= 2'h0;
    end else begin
      dreq_sync_q    <= {dreq_sync_q[0], card_dreq};
      removed_sync_q <= {removed_sync_q[0], card_removed};
    end
  end

  assign dreq_s    = dreq_sync_q[1];
  assign removed_s = removed_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic              aw_have_q, aw_have_d;
  logic              w_have_q, w_have_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              awready_q, awready_d;
  logic              wready_q, wready_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              arready_q, arready_d;
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;
  logic              gate_q, gate_d;
  logic [3:0]        tc_q, tc_d;
  logic [3:0]        req_stat_q, req_stat_d;
  logic              service_q, service_d;
  logic              clear_q, clear_d;
  logic              wr_fire;
  logic              clear_wr;
  logic              gate_wr;
  logic              ar_fire;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == STATUS_ADDR) || (a == CLEAR_ADDR) || (a == GATE_ADDR);
  endfunction

  assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  assign clear_wr = wr_fire && (waddr_q == CLEAR_ADDR);
  assign gate_wr  = wr_fire && (waddr_q == GATE_ADDR) && wstrb_q[0];
  assign ar_fire  = s_axi_arvalid && arready_q;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    waddr_d    = waddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    gate_d     = gate_q;
    tc_d       = tc_q;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_d  = 32'h0000_0000;
      if (s_axi_araddr == STATUS_ADDR) begin
        rdata_d[REQ_STAT_LSB +: STAT_FIELD_W] = req_stat_q;
        rdata_d[TC_STAT_LSB +: STAT_FIELD_W]  = tc_q;
        tc_d = TC_RESET;
      end
      if (s_axi_araddr == GATE_ADDR) begin
        rdata_d[GATE_BIT] = gate_q;
      end
    end
    if (gate_wr) begin
      gate_d = wdata_q[GATE_BIT];
    end
    if (clear_wr) begin
      gate_d = GATE_RESET;
      tc_d   = TC_RESET;
    end
    if (removed_s) begin
      gate_d = 1'b1;
    end
    if (terminal_count_hit) begin
      tc_d = {STAT_FIELD_W{1'b1}};
    end
    req_stat_d = {STAT_FIELD_W{dreq_s}};
    service_d  = dreq_s && !gate_q;
    clear_d    = clear_wr;
    awready_d  = !aw_have_d && !bvalid_d;
    wready_d   = !w_have_d && !bvalid_d;
    arready_d  = !rvalid_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      waddr_q    <= '0;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= RESP_OKAY;
      gate_q     <= GATE_RESET;
      tc_q       <= TC_RESET;
      req_stat_q <= 4'h0;
      service_q  <= 1'b0;
      clear_q    <= 1'b0;
    end else begin
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      gate_q     <= gate_d;
      tc_q       <= tc_d;
      req_stat_q <= req_stat_d;
      service_q  <= service_d;
      clear_q    <= clear_d;
    end
  end

  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign request_gate_bit    = gate_q;
  assign dma_service_request = service_q;
  assign controller_clear    = clear_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_clear_pulse_out: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    clear_wr |=> controller_clear ##1 !controller_clear)
    else $error("clear write gave no one-cycle clear pulse");
  chk_clear_gate_set: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    clear_wr |=> request_gate_bit)
    else $error("clear write left gate open");
  chk_clear_tc_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    clear_wr && !terminal_count_hit |=> tc_q == TC_RESET)
    else $error("clear write left terminal count set");
  chk_removal_sets_gate: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    removed_s |=> request_gate_bit)
    else $error("card removal did not set gate");
  chk_masked_no_service: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    request_gate_bit |=> !dma_service_request)
    else $error("service given while gated");
  chk_open_service: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    !request_gate_bit && dreq_s |=> dma_service_request)
    else $error("request not serviced while open");
  chk_status_follows: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    ##1 req_stat_q == {STAT_FIELD_W{$past(dreq_s)}})
    else $error("request status does not follow card line");
  chk_tc_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    terminal_count_hit |=> tc_q == {STAT_FIELD_W{1'b1}})
    else $error("terminal count status not set");
  chk_gate_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    ar_fire && s_axi_araddr == GATE_ADDR |=> s_axi_rvalid && s_axi_rdata[31:1] == 31'h0
      && s_axi_rdata[0] == $past(gate_q))
    else $error("gate read returned wrong bits");
  chk_reset_gate_up: assert property (@(posedge ref_clk)
    $rose(rst_n_q) |-> request_gate_bit)
    else $error("gate bit not set after reset");

endmodule // distributed_dma_clear_and_request_mask

/* shared/distributed_dma_gate_pkg.sv */
package distributed_dma_gate_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  STATUS_INDEX   = 8'h08;
  localparam logic [7:0]  CLEAR_INDEX    = 8'h0D;
  localparam logic [7:0]  GATE_INDEX     = 8'h0F;
  localparam logic [9:0]  STATUS_ADDR    = {STATUS_INDEX, 2'b00};
  localparam logic [9:0]  CLEAR_ADDR     = {CLEAR_INDEX, 2'b00};
  localparam logic [9:0]  GATE_ADDR      = {GATE_INDEX, 2'b00};
  localparam int          ADDR_W         = 10;
  // field layout of the status and gate registers
  localparam int          REQ_STAT_LSB   = 4;
  localparam int          TC_STAT_LSB    = 0;
  localparam int          STAT_FIELD_W   = 4;
  localparam int          GATE_BIT       = 0;
  // reset values
  localparam logic        GATE_RESET     = 1'b1;
  localparam logic [3:0]  TC_RESET       = 4'h0;
  // axi responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage
